// >>> src/fcb_flash_command_buffer_ctrl.sv
// flash command front end: registers, two-entry command queue, timebase
`default_nettype none
// What this block does
// RULE1: command code keeps only bits 6,5,2,0
// RULE2: only four codes run; others set access error
// RULE3: sector erase drops low nine address bits
// RULE4: mass erase starts from any array address
// RULE5: factory test registers read zero, ignore writes
// RULE6: address registers open only in special mode
// RULE7: data registers open in special mode only
// RULE8: command, address, data form two-entry queue
// RULE9: buffer empty and done flags raise interrupts
// RULE10: engine timed by divided oscillator timebase
// RULE11: software writes divider before any command
// RULE12: software keeps bus clock above minimum
// RULE13: software keeps timebase inside safe window
// RULE14: divider write sets loaded bit
// RULE15: unloaded divider blocks launch, sets access error
// RULE16: pre-divide bit plus six-bit divide field
// RULE17: pre-divide by eight, then field plus one
// RULE18: software: array write, code, launch order
// RULE19: error flags block launch; write one clears
module fcb_flash_command_buffer_ctrl
   import fcb_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  osc_clk_in,
   input  wire logic                  special_mode,
   input  wire logic                  protect_hit,
   input  wire logic [fcb_pkg::ADDR_W-1:0] avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   output logic                       irq,
   output logic                       engine_busy,
   output logic      [7:0]            engine_cmd,
   output logic      [15:0]           engine_addr,
   output logic      [15:0]           engine_data
);
   import fcb_pkg::*;

   // ****************************************
   // bus decode
   // ****************************************
   logic [3:0] idx;
   logic       acc_ok;
   logic       wr_stb;
   logic       rd_stb;
   logic       ack_reg;
   assign idx    = avs_address[5:2];
   assign acc_ok = (avs_address[1:0] == 2'b00);
   // every access takes exactly one wait cycle
   assign wr_stb = avs_write && ack_reg && acc_ok;
   assign rd_stb = avs_read && ack_reg;

   always_ff @(posedge clk) begin
      if (rst) ack_reg <= 1'b0;
      else ack_reg <= (avs_read || avs_write) && !ack_reg;
   end
   always_ff @(posedge clk) begin
      if (rst) avs_waitrequest <= 1'b1;
      else avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
   end

   // ****************************************
   // oscillator sync and timebase
   // ****************************************
   logic [2:0] osc_sync_reg;
   logic       osc_level_reg;
   logic       osc_rise;
   always_ff @(posedge clk) begin
      if (rst) osc_sync_reg <= 3'b000;
      else osc_sync_reg <= {osc_sync_reg[1:0], osc_clk_in};
   end
   always_ff @(posedge clk) begin
      if (rst) osc_level_reg <= 1'b0;
      else if (osc_sync_reg[1] == osc_sync_reg[2])
         osc_level_reg <= osc_sync_reg[2];
   end
   assign osc_rise = (osc_sync_reg[1] == osc_sync_reg[2])
                     && osc_sync_reg[2] && !osc_level_reg;

   logic [7:0] clkdiv_reg;
   logic [3:0] pre_cnt_reg;
   logic [5:0] div_cnt_reg;
   logic       pre_tick;
   logic       flash_timebase_clock_tick;
   assign pre_tick = osc_rise && (!clkdiv_reg[DIV_PRE8]          // RULE17
                     || pre_cnt_reg == PRE_DIV_LAST);
   // >= so a smaller new divide field never waits for a counter wrap
   assign flash_timebase_clock_tick = pre_tick && (div_cnt_reg >= clkdiv_reg[5:0]); // RULE16

   always_ff @(posedge clk) begin
      if (rst) pre_cnt_reg <= 4'h0;
      else if (osc_rise)
         pre_cnt_reg <= (pre_cnt_reg == PRE_DIV_LAST) ? 4'h0
                        : pre_cnt_reg + 4'h1;
   end
   always_ff @(posedge clk) begin
      if (rst) div_cnt_reg <= 6'h00;
      else if (flash_timebase_clock_tick) div_cnt_reg <= 6'h00;                  // RULE17
      else if (pre_tick) div_cnt_reg <= div_cnt_reg + 6'h01;
   end

   // divider register; bit 7 is the loaded flag
   always_ff @(posedge clk) begin
      if (rst) clkdiv_reg <= 8'h00;
      else if (wr_stb && idx == IDX_CLKDIV)
         clkdiv_reg <= {1'b1, avs_writedata[6:0]};               // RULE14
   end

   // ****************************************
   // command write sequence and queue
   // ****************************************
   logic [7:0]  status_reg;
   logic [7:0]  cmd_reg;
   logic [15:0] addr_reg;
   logic [15:0] data_reg;
   logic        seq_addr_reg;
   logic        pend_reg;
   logic [7:0]  pend_cmd_reg;
   logic [15:0] pend_addr_reg;
   logic [15:0] pend_data_reg;
   logic [7:0]  tick_cnt_reg;
   fcb_state_t  state_reg;
   logic        array_wr;
   logic        launch_req;
   logic        legal_cmd;
   logic        blocked;
   logic        launch_ok;
   logic        launch_bad;
   logic        start_next;
   logic        finish;
   logic [7:0]  cmd_ticks;

   assign array_wr   = wr_stb && idx == IDX_ARRAY;              // RULE4
   assign launch_req = wr_stb && idx == IDX_STATUS
                       && avs_writedata[ST_BUF_EMPTY]
                       && status_reg[ST_BUF_EMPTY] == 1'b0 ? 1'b0
                       : wr_stb && idx == IDX_STATUS
                       && avs_writedata[ST_BUF_EMPTY] && seq_addr_reg;
   assign legal_cmd  = cmd_reg == CMD_VERIFY || cmd_reg == CMD_PROGRAM
                       || cmd_reg == CMD_SECTOR || cmd_reg == CMD_MASS;
   assign blocked    = status_reg[ST_ACCESS_ERROR_FLAG] || status_reg[ST_PROTECTION_VIOLATION_FLAG]; // RULE19
   assign launch_bad = launch_req && !blocked
                       && (!legal_cmd || !clkdiv_reg[DIV_LOADED]); // RULE2 RULE15
   assign launch_ok  = launch_req && !blocked && legal_cmd
                       && clkdiv_reg[DIV_LOADED] && !protect_hit
                       && !pend_reg;                              // RULE8
   assign finish     = state_reg == FCB_RUN && flash_timebase_clock_tick
                       && tick_cnt_reg == 8'h00;                  // RULE10
   assign start_next = pend_reg && (state_reg == FCB_IDLE || finish);

   always_comb begin
      case (pend_cmd_reg)
         CMD_VERIFY:  cmd_ticks = TICKS_VERIFY;
         CMD_PROGRAM: cmd_ticks = TICKS_PROGRAM;
         default:     cmd_ticks = TICKS_ERASE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) seq_addr_reg <= 1'b0;
      else if (array_wr && status_reg[ST_BUF_EMPTY]) seq_addr_reg <= 1'b1;
      else if (launch_req) seq_addr_reg <= 1'b0;
   end

   // capture stage; special mode may also poke it directly
   always_ff @(posedge clk) begin
      if (rst) begin
         addr_reg <= 16'h0000;
         data_reg <= 16'h0000;
      end else if (array_wr && status_reg[ST_BUF_EMPTY]) begin
         addr_reg <= avs_writedata[31:16];
         data_reg <= avs_writedata[15:0];
      end else if (wr_stb && special_mode) begin                 // RULE6 RULE7
         case (idx)
            IDX_ADDR_HI: addr_reg[15:8] <= avs_writedata[7:0];
            IDX_ADDR_LO: addr_reg[7:0]  <= avs_writedata[7:0];
            IDX_DATA_HI: data_reg[15:8] <= avs_writedata[7:0];
            IDX_DATA_LO: data_reg[7:0]  <= avs_writedata[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) cmd_reg <= 8'h00;
      else if (wr_stb && idx == IDX_CMD && seq_addr_reg)
         cmd_reg <= avs_writedata[7:0] & CMD_MASK;               // RULE1
   end

   // second stage: waits while the engine runs
   always_ff @(posedge clk) begin
      if (rst) begin
         pend_reg      <= 1'b0;
         pend_cmd_reg  <= 8'h00;
         pend_addr_reg <= 16'h0000;
         pend_data_reg <= 16'h0000;
      end else if (launch_ok) begin
         pend_reg      <= 1'b1;
         pend_cmd_reg  <= cmd_reg;
         pend_addr_reg <= (cmd_reg == CMD_SECTOR)
                          ? (addr_reg & ~{7'h00, SECTOR_IGNORE})  // RULE3
                          : addr_reg;
         pend_data_reg <= data_reg;
      end else if (start_next) pend_reg <= 1'b0;
   end

   // ****************************************
   // engine
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) state_reg <= FCB_IDLE;
      else case (state_reg)
         FCB_IDLE: if (start_next) state_reg <= FCB_RUN;
         FCB_RUN:  if (finish && !pend_reg) state_reg <= FCB_IDLE;
         default:  state_reg <= FCB_IDLE;
      endcase
   end
   always_ff @(posedge clk) begin
      if (rst) tick_cnt_reg <= 8'h00;
      else if (start_next) tick_cnt_reg <= cmd_ticks;
      else if (state_reg == FCB_RUN && flash_timebase_clock_tick && tick_cnt_reg != 8'h00)
         tick_cnt_reg <= tick_cnt_reg - 8'h01;                    // RULE10
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         engine_cmd  <= 8'h00;
         engine_addr <= 16'h0000;
         engine_data <= 16'h0000;
      end else if (start_next) begin
         engine_cmd  <= pend_cmd_reg;
         engine_addr <= pend_addr_reg;
         engine_data <= pend_data_reg;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) engine_busy <= 1'b0;
      else engine_busy <= (state_reg == FCB_RUN && !(finish && !pend_reg))
                          || start_next;
   end

   // ****************************************
   // status flags; hardware set beats software clear
   // ****************************************
   logic stat_clr;
   assign stat_clr = wr_stb && idx == IDX_STATUS;
   always_ff @(posedge clk) begin
      if (rst) status_reg <= STATUS_RESET;
      else begin
         // buffer empty: clears on launch, sets once stage two frees
         if (launch_ok) status_reg[ST_BUF_EMPTY] <= 1'b0;
         else if (!pend_reg || start_next) status_reg[ST_BUF_EMPTY] <= 1'b1;
         if (launch_ok) status_reg[ST_CMD_DONE] <= 1'b0;
         else if (finish && !pend_reg) status_reg[ST_CMD_DONE] <= 1'b1;
         if (launch_req && !blocked && protect_hit && legal_cmd
             && clkdiv_reg[DIV_LOADED])
            status_reg[ST_PROTECTION_VIOLATION_FLAG] <= 1'b1;
         else if (stat_clr && avs_writedata[ST_PROTECTION_VIOLATION_FLAG])
            status_reg[ST_PROTECTION_VIOLATION_FLAG] <= 1'b0;                        // RULE19
         if (launch_bad) status_reg[ST_ACCESS_ERROR_FLAG] <= 1'b1;         // RULE2
         else if (stat_clr && avs_writedata[ST_ACCESS_ERROR_FLAG])
            status_reg[ST_ACCESS_ERROR_FLAG] <= 1'b0;                       // RULE19
         if (launch_ok) status_reg[ST_BLANK] <= 1'b0;
         else if (finish && engine_cmd == CMD_VERIFY)
            status_reg[ST_BLANK] <= 1'b1;
      end
   end

   // ****************************************
   // interrupt: sticky events, w1c, masked
   // ****************************************
   logic [1:0] event_reg;
   logic [1:0] mask_reg;
   always_ff @(posedge clk) begin
      if (rst) mask_reg <= 2'b00;
      else if (wr_stb && idx == IDX_MASK) mask_reg <= avs_writedata[1:0];
   end
   always_ff @(posedge clk) begin
      if (rst) event_reg <= 2'b00;
      else begin                                                 // RULE9
         // buffer empty rises when stage two hands over to the engine
         event_reg[0] <= (!status_reg[ST_BUF_EMPTY] && start_next)
                         || (event_reg[0] && !(wr_stb && idx == IDX_EVENTS
                         && avs_writedata[0]));
         event_reg[1] <= (finish && !pend_reg)
                         || (event_reg[1] && !(wr_stb && idx == IDX_EVENTS
                         && avs_writedata[1]));
      end
   end
   always_ff @(posedge clk) begin
      if (rst) irq <= 1'b0;
      else irq <= |(event_reg & mask_reg);                       // RULE9
   end

   // ****************************************
   // read mux
   // ****************************************
   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = 8'h00;                                           // RULE5
      case (idx)
         IDX_CLKDIV: rd_byte = clkdiv_reg;
         IDX_STATUS: rd_byte = status_reg;
         IDX_CMD:    rd_byte = cmd_reg;
         IDX_MASK:   rd_byte = {6'h00, mask_reg};
         IDX_EVENTS: rd_byte = {6'h00, event_reg};
         IDX_ADDR_HI: rd_byte = special_mode ? addr_reg[15:8] : 8'h00; // RULE6
         IDX_ADDR_LO: rd_byte = special_mode ? addr_reg[7:0] : 8'h00;
         IDX_DATA_HI: rd_byte = special_mode ? data_reg[15:8] : 8'h00; // RULE7
         IDX_DATA_LO: rd_byte = special_mode ? data_reg[7:0] : 8'h00;
         default:    rd_byte = 8'h00;
      endcase
   end
   always_ff @(posedge clk) begin
      if (rst) avs_readdata <= 32'h0000_0000;
      else if (avs_read && !ack_reg) avs_readdata <= {24'h00_0000, rd_byte};
   end

   // ****************************************
   // checks
   // ****************************************
   chk_cmd_bits: assert property (@(posedge clk) disable iff (rst) // RULE1
      (cmd_reg & ~CMD_MASK) == 8'h00) else $error("command stray bits");
   chk_bad_code: assert property (@(posedge clk) disable iff (rst) // RULE2
      launch_req && !blocked && !legal_cmd |=> status_reg[ST_ACCESS_ERROR_FLAG])
      else $error("illegal code not flagged");
   chk_sector_low: assert property (@(posedge clk) disable iff (rst) // RULE3
      launch_ok && cmd_reg == CMD_SECTOR |=> pend_addr_reg[8:0] == 9'h000)
      else $error("sector low bits kept");
   chk_test_zero: assert property (@(posedge clk) disable iff (rst) // RULE5
      avs_read && !ack_reg && idx == IDX_TEST_C
      |=> avs_readdata == 32'h0000_0000) else $error("test reg nonzero");
   chk_addr_hidden: assert property (@(posedge clk) disable iff (rst) // RULE6
      avs_read && !ack_reg && idx == IDX_ADDR_HI && !special_mode
      |=> avs_readdata == 32'h0000_0000) else $error("address visible");
   chk_queue_one: assert property (@(posedge clk) disable iff (rst) // RULE8
      pend_reg && !start_next |=> pend_reg) else $error("queue lost entry");
   chk_div_load: assert property (@(posedge clk) disable iff (rst) // RULE14
      wr_stb && idx == IDX_CLKDIV |=> clkdiv_reg[DIV_LOADED])
      else $error("loaded bit not set");
   chk_no_div: assert property (@(posedge clk) disable iff (rst) // RULE15
      launch_req && !clkdiv_reg[DIV_LOADED] |-> !launch_ok)
      else $error("launch without divider");
   chk_err_block: assert property (@(posedge clk) disable iff (rst) // RULE19
      blocked |-> !launch_ok) else $error("launch while error set");
   cov_launch: cover property (@(posedge clk) launch_ok);
   cov_back_to_back: cover property (@(posedge clk) pend_reg && engine_busy);
   chk_empty_event: assert property (@(posedge clk) disable iff (rst) // RULE9
      !status_reg[ST_BUF_EMPTY] && start_next |=> event_reg[0])
      else $error("buffer empty event missed");
   chk_irq_level: assert property (@(posedge clk) disable iff (rst) // RULE9
      |(event_reg & mask_reg) |=> irq) else $error("interrupt not raised");
   chk_protection_violation_flag_set: assert property (@(posedge clk) disable iff (rst) // RULE19
      launch_req && !blocked && protect_hit && legal_cmd
      && clkdiv_reg[DIV_LOADED] |=> status_reg[ST_PROTECTION_VIOLATION_FLAG])
      else $error("protection violation not flagged");
   chk_addr_locked: assert property (@(posedge clk) disable iff (rst) // RULE6
      wr_stb && !special_mode && idx == IDX_ADDR_HI |=> $stable(addr_reg))
      else $error("address written in normal mode");
   chk_data_locked: assert property (@(posedge clk) disable iff (rst) // RULE7
      wr_stb && !special_mode && idx == IDX_DATA_LO |=> $stable(data_reg))
      else $error("data written in normal mode");
   // main scenarios: launch, queued pair, error, handover, prescaled tick
   cov_access_error_flag: cover property (@(posedge clk) launch_bad);
   cov_buf_event: cover property (@(posedge clk)
      !status_reg[ST_BUF_EMPTY] && start_next);
   cov_prescale: cover property (@(posedge clk)
      flash_timebase_clock_tick && clkdiv_reg[DIV_PRE8]);
endmodule // fcb_flash_command_buffer_ctrl
`default_nettype wire

// >>> src/fcb_pkg.sv
// package: register map, field positions, command codes and timing for fcb
`default_nettype none
package fcb_pkg;
   // register indices on the avalon bus (address bits 5:2), one 32-bit word per register index
   localparam logic [5:0] ADDR_W = 6'h06;
   localparam logic [3:0] IDX_CLKDIV   = 4'h0;
   localparam logic [3:0] IDX_CONFIG   = 4'h3;
   localparam logic [3:0] IDX_STATUS   = 4'h5;
   localparam logic [3:0] IDX_CMD      = 4'h6;
   localparam logic [3:0] IDX_TEST_A   = 4'h7;
   localparam logic [3:0] IDX_ADDR_HI  = 4'h8;
   localparam logic [3:0] IDX_ADDR_LO  = 4'h9;
   localparam logic [3:0] IDX_DATA_HI  = 4'ha;
   localparam logic [3:0] IDX_DATA_LO  = 4'hb;
   localparam logic [3:0] IDX_TEST_B   = 4'hc;
   localparam logic [3:0] IDX_TEST_C   = 4'hd;
   localparam logic [3:0] IDX_TEST_D   = 4'he;
   localparam logic [3:0] IDX_TEST_E   = 4'hf;
   localparam logic [3:0] IDX_ARRAY    = 4'h1;
   localparam logic [3:0] IDX_MASK     = 4'h2;
   localparam logic [3:0] IDX_EVENTS   = 4'h4;
   // command code bits that exist
   localparam logic [7:0] CMD_MASK     = 8'h65;
   localparam logic [7:0] CMD_VERIFY   = 8'h05;
   localparam logic [7:0] CMD_PROGRAM  = 8'h20;
   localparam logic [7:0] CMD_SECTOR   = 8'h40;
   localparam logic [7:0] CMD_MASS     = 8'h41;
   // status bits
   localparam int ST_BUF_EMPTY = 7;
   localparam int ST_CMD_DONE  = 6;
   localparam int ST_PROTECTION_VIOLATION_FLAG     = 5;
   localparam int ST_ACCESS_ERROR_FLAG    = 4;
   localparam int ST_BLANK     = 2;
   // clock divider fields
   localparam int DIV_LOADED   = 7;
   localparam int DIV_PRE8     = 6;
   localparam logic [3:0] PRE_DIV_LAST = 4'h7;
   localparam logic [8:0] SECTOR_IGNORE = 9'h1ff;
   localparam logic [7:0] STATUS_RESET = 8'hc0;
   // flash timebase cycles per command kind
   localparam logic [7:0] TICKS_VERIFY  = 8'h04;
   localparam logic [7:0] TICKS_PROGRAM = 8'h08;
   localparam logic [7:0] TICKS_ERASE   = 8'h20;
   typedef enum logic [1:0] {FCB_IDLE, FCB_RUN} fcb_state_t;
endpackage : fcb_pkg
`default_nettype wire

// >>> verification/fcb_flash_command_buffer_ctrl_tb.sv
// self-checking bench for the flash command front end
`default_nettype none
module fcb_flash_command_buffer_ctrl_tb;
   import fcb_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   // ************************************************
   // signals and instance
   // ************************************************
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic              osc_clk_in = 1'b0;
   logic              special_mode = 1'b0;
   logic              protect_hit = 1'b0;
   logic [ADDR_W-1:0] avs_address = '0;
   logic              avs_read = 1'b0;
   logic              avs_write = 1'b0;
   logic [31:0]       avs_writedata = '0;
   logic [31:0]       avs_readdata;
   logic              avs_waitrequest;
   logic              irq;
   logic              engine_busy;
   logic [7:0]        engine_cmd;
   logic [15:0]       engine_addr;
   logic [15:0]       engine_data;
   int                fail_count = 0;
   int                checks = 0;
   logic [7:0]        rv;
   logic [7:0]        bad_codes [4] = '{8'h01, 8'h24, 8'h60, 8'h65};
   logic [3:0]        test_idx [6] = '{4'h3, 4'h7, 4'hc, 4'hd, 4'he, 4'hf};

   fcb_flash_command_buffer_ctrl i_fcb_flash_command_buffer_ctrl (
      .clk(clk), .rst(rst), .osc_clk_in(osc_clk_in),
      .special_mode(special_mode), .protect_hit(protect_hit),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .irq(irq), .engine_busy(engine_busy), .engine_cmd(engine_cmd),
      .engine_addr(engine_addr), .engine_data(engine_data));

   initial begin
      forever #50 clk = ~clk;
   end
   // unrelated oscillator, 600 ns period: each level lasts three
   // bus clocks, long enough for the pin filter to accept it
   initial begin
      #17;
      forever #300 osc_clk_in = ~osc_clk_in;
   end
   // ************************************************
   // tasks
   // ************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // a fresh edge first, so no strobe is set twice in one step
   task automatic bus(input logic wr, input logic [3:0] idx,
                      input logic [31:0] wd, output logic [7:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      avs_address   <= {idx, 2'b00};
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_writedata <= wd;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) check(32'h0, 32'h1);
      rd = avs_readdata[7:0];
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] idx, input logic [31:0] wd);
      logic [7:0] d;
      bus(1'b1, idx, wd, d);
   endtask
   task automatic rd(input logic [3:0] idx, output logic [7:0] d);
      bus(1'b0, idx, 32'h0, d);
   endtask
   task automatic launch(input logic [7:0] cmd, input logic [15:0] a,
                         input logic [15:0] d);
      wr(IDX_ARRAY, {a, d});
      wr(IDX_CMD, {24'h0, cmd});
      wr(IDX_STATUS, 32'h0000_0080);
   endtask
   task automatic wait_busy();
      int n;
      n = 0;
      while (engine_busy !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      check({31'h0, engine_busy}, 32'h1);
   endtask
   task automatic wait_done();
      logic [7:0] s;
      int         n;
      n = 0;
      do begin
         rd(IDX_STATUS, s);
         n++;
      end while (s[ST_CMD_DONE] !== 1'b1 && n < 400);
      check({31'h0, s[ST_CMD_DONE]}, 32'h1);
   endtask
   // busy span must follow ticks * divide * osc period
   task automatic timed_program(input int expect_cyc);
      int m;
      m = 0;
      launch(CMD_PROGRAM, 16'h0100, 16'h1234);
      wait_busy();
      while (engine_busy === 1'b1 && m < 3000) begin
         @(posedge clk);
         m++;
      end
      check({31'h0, (m >= expect_cyc - expect_cyc / 8 &&
             m <= expect_cyc + expect_cyc / 8 + 4)}, 32'h1);
      wait_done();
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ************************************************
   // tests
   // ************************************************
   initial begin
      #2_000_000;
      fail_count++;
      give_verdict();
   end

   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(IDX_STATUS, rv);
      check(rv, STATUS_RESET);
      rd(IDX_CLKDIV, rv);
      check(rv, 32'h0);
      check({31'h0, irq}, 32'h0);
      // launch before the divider is loaded
      launch(CMD_PROGRAM, 16'h0100, 16'h5555);
      rd(IDX_STATUS, rv);
      check(rv & 8'h30, 8'h10);
      check({31'h0, engine_busy}, 32'h0);
      wr(IDX_CLKDIV, 32'h0000_0001);
      rd(IDX_CLKDIV, rv);
      check(rv, 8'h81);
      launch(CMD_PROGRAM, 16'h0100, 16'h5555);
      repeat (10) @(posedge clk);
      check({31'h0, engine_busy}, 32'h0);
      wr(IDX_STATUS, 32'h0000_0010);
      rd(IDX_STATUS, rv);
      check(rv & 8'h30, 8'h00);
      $display("test divider gate done");
      // command code storage bits
      wr(IDX_ARRAY, 32'h0100_0000);
      wr(IDX_CMD, 32'h0000_00ff);
      rd(IDX_CMD, rv);
      check(rv, CMD_MASK);
      wr(IDX_CMD, 32'h0000_0000);
      rd(IDX_CMD, rv);
      check(rv, 8'h00);
      wr(IDX_STATUS, 32'h0000_0080);
      rd(IDX_STATUS, rv);
      check(rv & 8'h10, 8'h10);
      wr(IDX_STATUS, 32'h0000_0010);
      for (int i = 0; i < 4; i++) begin
         launch(bad_codes[i], 16'h0200, 16'h0);
         rd(IDX_STATUS, rv);
         check(rv & 8'h10, 8'h10);
         wr(IDX_STATUS, 32'h0000_0010);
      end
      $display("test command codes done");
      // timebase: 8 ticks, field 1 -> 2 osc rises per tick
      timed_program(8 * 2 * 6);
      check(engine_cmd, CMD_PROGRAM);
      check(engine_data, 16'h1234);
      wr(IDX_CLKDIV, 32'h0000_0040);
      rd(IDX_CLKDIV, rv);
      check(rv, 8'hc0);
      timed_program(8 * 8 * 6);
      wr(IDX_CLKDIV, 32'h0000_0001);
      $display("test timebase done");
      // verify, sector and mass erase, with interrupt on completion
      wr(IDX_MASK, 32'h0000_0002);
      rd(IDX_MASK, rv);
      check(rv, 8'h02);
      wr(IDX_EVENTS, 32'h0000_0003);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h0);
      launch(CMD_VERIFY, 16'h0300, 16'h0);
      wait_busy();
      check(engine_cmd, CMD_VERIFY);
      wait_done();
      rd(IDX_EVENTS, rv);
      check(rv, 8'h03);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h1);
      wr(IDX_EVENTS, 32'h0000_0002);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h0);
      launch(CMD_SECTOR, 16'h12ff, 16'h0);
      wait_busy();
      check(engine_addr, 16'h1200);
      wait_done();
      launch(CMD_MASS, 16'hbeef, 16'h0);
      wait_busy();
      check(engine_cmd, CMD_MASS);
      wait_done();
      $display("test legal commands done");
      // second command queued behind a running one
      launch(CMD_PROGRAM, 16'h0400, 16'haaaa);
      wait_busy();
      rd(IDX_STATUS, rv);
      check(rv & 8'hc0, 8'h80);
      launch(CMD_PROGRAM, 16'h0402, 16'hbbbb);
      while (engine_busy === 1'b1 && engine_data !== 16'hbbbb)
         @(posedge clk);
      check(engine_data, 16'hbbbb);
      check({31'h0, engine_busy}, 32'h1);
      wait_done();
      $display("test queue done");
      // protected target
      protect_hit <= 1'b1;
      launch(CMD_PROGRAM, 16'h0500, 16'h00c3);
      rd(IDX_STATUS, rv);
      check(rv & 8'h20, 8'h20);
      check({31'h0, engine_busy}, 32'h0);
      protect_hit <= 1'b0;
      wr(IDX_STATUS, 32'h0000_0020);
      rd(IDX_STATUS, rv);
      check(rv & 8'h20, 8'h00);
      $display("test protection done");
      // test and unused places, mode dependent registers
      for (int i = 0; i < 6; i++) begin
         wr(test_idx[i], 32'h0000_00ff);
         rd(test_idx[i], rv);
         check(rv, 8'h00);
      end
      wr(IDX_ADDR_HI, 32'h0000_00ab);
      rd(IDX_ADDR_HI, rv);
      check(rv, 8'h00);
      rd(IDX_DATA_LO, rv);
      check(rv, 8'h00);
      special_mode <= 1'b1;
      wr(IDX_ADDR_HI, 32'h0000_005a);
      rd(IDX_ADDR_HI, rv);
      check(rv, 8'h5a);
      wr(IDX_DATA_HI, 32'h0000_003c);
      rd(IDX_DATA_HI, rv);
      check(rv, 8'h3c);
      special_mode <= 1'b0;
      $display("test register access done");
      give_verdict();
   end
endmodule // fcb_flash_command_buffer_ctrl_tb
`default_nettype wire
